// file: verilog/ssp_datapath.v
`timescale 1ns/1ps
`include "ssp_consts.vh"
module ssp_datapath #(
  parameter TCYC_CLKS = `SSP_TCYC_CLKS
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire [17:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [17:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire sck_in,
  output reg sck_out,
  output reg sck_oe_out,
  input wire sdi_in,
  output reg sdo_out,
  input wire deep_sleep_in,
  output reg wake_mode_out,
  output reg wake_irq_out,
  output reg [8:0] ram_addr_out,
  output reg ram_rd_out,
  output reg ram_wr_out,
  output reg [7:0] ram_wdata_out,
  input wire [7:0] ram_rdata_in
);
  localparam ST_IDLE = 3'h0;
  localparam ST_READ = 3'h1;
  localparam ST_LOAD = 3'h2;
  localparam ST_SHIFT = 3'h3;
  localparam ST_PAUSE = 3'h4;
  localparam integer UNIT_CLKS = (TCYC_CLKS / 3 < 1) ? 1 : TCYC_CLKS / 3;

  // ***************************************************************
  // Reset and input synchronisers
  // ***************************************************************
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  reg [2:0] meta_reg;
  reg [2:0] sync_reg;
  reg sck_dly_reg;
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= 3'h1;
      sync_reg <= 3'h1;
      sck_dly_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= {deep_sleep_in, sdi_in, sck_in};
      sync_reg <= meta_reg;
      sck_dly_reg <= sync_reg[0];
    end
  end
  wire ext_rise = sync_reg[0] & ~sck_dly_reg;
  wire ext_fall = ~sync_reg[0] & sck_dly_reg;
  wire sdi_s = sync_reg[1];
  wire sleep_s = sync_reg[2];

  // ***************************************************************
  // Registers
  // ***************************************************************
  reg [7:0] shift_reg;
  reg [7:0] rate_reg;
  reg [7:0] len_reg;
  reg pause_reg;
  reg [1:0] code_reg;
  reg [4:0] bytes_reg;
  reg [7:0] wake_shift_reg;
  reg [5:0] wake_ctl_reg;
  reg bank_reg;
  reg swap_reg;
  reg run_reg;
  reg cont_reg;
  reg msb_reg;
  reg end_reg;
  reg ext_clk_reg;

  // ***************************************************************
  // AXI4-Lite slave
  // ***************************************************************
  reg aw_got_reg;
  reg w_got_reg;
  reg [15:0] aw_idx_reg;
  reg [7:0] wd_reg;
  reg wd_en_reg;
  assign s_axi_awready_out = ~aw_got_reg & ~s_axi_bvalid_out;
  assign s_axi_wready_out = ~w_got_reg & ~s_axi_bvalid_out;
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  wire wr_go = aw_got_reg & w_got_reg & ~s_axi_bvalid_out;
  wire wr_en = wr_go & wd_en_reg;
  wire wr_shift = wr_en & (aw_idx_reg == `SSP_IDX_SHIFT_DATA);
  wire wr_rate = wr_en & (aw_idx_reg == `SSP_IDX_BIT_RATE);
  wire wr_len = wr_en & (aw_idx_reg == `SSP_IDX_CONT_LEN);
  wire wr_cc = wr_en & (aw_idx_reg == `SSP_IDX_CONT_CTRL);
  wire wr_wshift = wr_en & (aw_idx_reg == `SSP_IDX_WAKE_SHIFT);
  wire wr_wctl = wr_en & (aw_idx_reg == `SSP_IDX_WAKE_CTRL);
  wire wr_pc = wr_en & (aw_idx_reg == `SSP_IDX_PORT_CTRL);
  wire aw_map = (aw_idx_reg == `SSP_IDX_SHIFT_DATA) | (aw_idx_reg == `SSP_IDX_BIT_RATE) |
                (aw_idx_reg == `SSP_IDX_CONT_LEN) | (aw_idx_reg == `SSP_IDX_CONT_CTRL) |
                (aw_idx_reg == `SSP_IDX_WAKE_SHIFT) | (aw_idx_reg == `SSP_IDX_WAKE_CTRL) |
                (aw_idx_reg == `SSP_IDX_PORT_CTRL);

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_idx_reg <= 16'h0000;
      wd_reg <= 8'h00;
      wd_en_reg <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `SSP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_got_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr_in[17:2];
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_got_reg <= 1'b1;
        wd_reg <= s_axi_wdata_in[7:0];
        wd_en_reg <= s_axi_wstrb_in[0];
      end
      if (wr_go)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= aw_map ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  reg [7:0] rd_mux;
  reg rd_map;
  always @*
  begin
    rd_map = 1'b1;
    case (s_axi_araddr_in[17:2])
      `SSP_IDX_SHIFT_DATA: rd_mux = shift_reg;
      `SSP_IDX_BIT_RATE: rd_mux = rate_reg;
      `SSP_IDX_CONT_LEN: rd_mux = len_reg;
      `SSP_IDX_CONT_CTRL: rd_mux = {pause_reg, code_reg, bytes_reg};
      `SSP_IDX_WAKE_SHIFT: rd_mux = wake_shift_reg;
      `SSP_IDX_WAKE_CTRL: rd_mux = {2'h0, wake_ctl_reg};
      `SSP_IDX_PORT_CTRL: rd_mux = {bank_reg, swap_reg, run_reg, cont_reg, msb_reg, 1'b0,
                                     end_reg, ext_clk_reg};
      default:
      begin
        rd_mux = 8'h00;
        rd_map = 1'b0;
      end
    endcase
  end

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `SSP_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h000000, rd_mux};
      s_axi_rresp_out <= rd_map ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
    end
    else if (s_axi_rvalid_out && s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

  // ***************************************************************
  // Bit-rate generator
  // ***************************************************************
  reg [2:0] state_reg;
  reg [7:0] baud_cnt_reg;
  reg [7:0] unit_cnt_reg;
  wire shifting = (state_reg == ST_SHIFT);
  wire unit_tick = (unit_cnt_reg == (UNIT_CLKS[7:0] - 8'h01));
  wire baud_tick = shifting & ~ext_clk_reg & unit_tick & (baud_cnt_reg == 8'h00);
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baud_cnt_reg <= 8'h00;
      unit_cnt_reg <= 8'h00;
    end
    else if (!shifting)
    begin
      baud_cnt_reg <= rate_reg;
      unit_cnt_reg <= 8'h00;
    end
    else
    begin
      unit_cnt_reg <= unit_tick ? 8'h00 : unit_cnt_reg + 8'h01;
      if (unit_tick)
        baud_cnt_reg <= (baud_cnt_reg == 8'h00) ? rate_reg : baud_cnt_reg - 8'h01;
    end
  end
  wire fall_ev = shifting & (ext_clk_reg ? ext_fall : (baud_tick & sck_out));
  wire rise_ev = shifting & (ext_clk_reg ? ext_rise : (baud_tick & ~sck_out));

  // ***************************************************************
  // Transfer engine
  // ***************************************************************
  reg [8:0] bits_left_reg;
  reg [2:0] bit_cnt_reg;
  reg [4:0] ram_off_reg;
  reg cur_bit_reg;
  wire [8:0] base = bank_reg ? `SSP_RAM_BANK1 : `SSP_RAM_BANK0;
  wire last_bit = (bits_left_reg == 9'h001);
  wire tx_bit = msb_reg ? shift_reg[7] : shift_reg[0];
  wire start = wr_pc & wd_reg[`SSP_PC_RUN] & (state_reg == ST_IDLE);

  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      shift_reg <= `SSP_RST_BYTE;
      bits_left_reg <= 9'h000;
      bit_cnt_reg <= 3'h0;
      ram_off_reg <= 5'h00;
      bytes_reg <= 5'h00;
      run_reg <= 1'b0;
      cont_reg <= 1'b0;
      end_reg <= 1'b0;
      sck_out <= 1'b1;
      sdo_out <= 1'b1;
      cur_bit_reg <= 1'b0;
      ram_addr_out <= 9'h000;
      ram_rd_out <= 1'b0;
      ram_wr_out <= 1'b0;
      ram_wdata_out <= 8'h00;
    end
    else
    begin
      ram_rd_out <= 1'b0;
      ram_wr_out <= 1'b0;
      if (wr_pc)
      begin
        cont_reg <= wd_reg[`SSP_PC_CONT];
        if (!wd_reg[`SSP_PC_END])
          end_reg <= 1'b0;
      end
      if (wr_shift && state_reg == ST_IDLE)
        shift_reg <= wd_reg;
      case (state_reg)
        ST_IDLE:
        begin
          sck_out <= 1'b1;
          if (start)
          begin
            run_reg <= 1'b1;
            bit_cnt_reg <= 3'h0;
            bytes_reg <= 5'h00;
            ram_off_reg <= 5'h00;
            if (wd_reg[`SSP_PC_CONT])
            begin
              bits_left_reg <= {1'b0, len_reg} + 9'h001;
              state_reg <= ST_READ;
            end
            else
            begin
              bits_left_reg <= 9'h008;
              state_reg <= ST_SHIFT;
            end
          end
        end
        ST_READ:
        begin
          ram_addr_out <= base + {4'h0, ram_off_reg};
          ram_rd_out <= 1'b1;
          state_reg <= ST_LOAD;
        end
        ST_LOAD:
        begin
          shift_reg <= ram_rdata_in;
          ram_wr_out <= swap_reg;
          ram_wdata_out <= shift_reg;
          state_reg <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          if (!ext_clk_reg && baud_tick)
            sck_out <= ~sck_out;
          if (fall_ev)
          begin
            cur_bit_reg <= tx_bit;
            if (code_reg == `SSP_CODE_BPS)
              sdo_out <= ~sdo_out;
            else
              sdo_out <= tx_bit;
          end
          if (rise_ev)
          begin
            if (code_reg == `SSP_CODE_MAN1)
              sdo_out <= ~cur_bit_reg;
            else if (code_reg == `SSP_CODE_MAN2 && !last_bit)
              sdo_out <= ~cur_bit_reg;
            else if (code_reg == `SSP_CODE_BPS && !cur_bit_reg)
              sdo_out <= ~sdo_out;
            else if (code_reg == `SSP_CODE_NRZ)
              sdo_out <= cur_bit_reg;
            shift_reg <= msb_reg ? {shift_reg[6:0], sdi_s} : {sdi_s, shift_reg[7:1]};
            bits_left_reg <= bits_left_reg - 9'h001;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7 && cont_reg)
              bytes_reg <= bytes_reg + 5'h01;
            if (last_bit)
            begin
              run_reg <= 1'b0;
              cont_reg <= 1'b0;
              end_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
            else if (bit_cnt_reg == 3'h7 && cont_reg)
            begin
              ram_off_reg <= ram_off_reg + 5'h01;
              state_reg <= pause_reg ? ST_PAUSE : ST_READ;
            end
          end
        end
        ST_PAUSE:
        begin
          if (!pause_reg)
            state_reg <= ST_READ;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // Software-held configuration
  // ***************************************************************
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_reg <= `SSP_RST_BYTE;
      len_reg <= `SSP_RST_BYTE;
      pause_reg <= 1'b0;
      code_reg <= `SSP_CODE_NRZ;
      bank_reg <= 1'b0;
      swap_reg <= 1'b0;
      msb_reg <= 1'b0;
      ext_clk_reg <= 1'b0;
      sck_oe_out <= 1'b0;
    end
    else
    begin
      sck_oe_out <= ~ext_clk_reg;
      if (wr_rate)
        rate_reg <= wd_reg;
      if (wr_len)
        len_reg <= wd_reg;
      if (wr_cc)
      begin
        pause_reg <= wd_reg[`SSP_CC_PAUSE];
        code_reg <= wd_reg[`SSP_CC_CODE_HI:`SSP_CC_CODE_LO];
      end
      if (wr_pc)
      begin
        bank_reg <= wd_reg[`SSP_PC_BANK];
        swap_reg <= wd_reg[`SSP_PC_SWAP];
        msb_reg <= wd_reg[`SSP_PC_MSB];
        ext_clk_reg <= wd_reg[`SSP_PC_EXT_CLK];
      end
    end
  end

  // ***************************************************************
  // Wake receiver
  // ***************************************************************
  reg [2:0] wake_bits_reg;
  reg [3:0] idle_bits_reg;
  wire w_arm = wake_ctl_reg[`SSP_WC_ARM];
  wire w_acc = wake_ctl_reg[`SSP_WC_ACCEPT];
  wire w_take = ext_rise & w_arm & w_acc;
  wire w_done_set = w_take & (wake_bits_reg == 3'h7);
  wire w_ovr_set = ext_rise & w_arm & ~w_acc & (idle_bits_reg == `SSP_WAKE_OVR_BITS - 4'h1);
  always @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_shift_reg <= `SSP_RST_BYTE;
      wake_ctl_reg <= 6'h00;
      wake_bits_reg <= 3'h0;
      idle_bits_reg <= 4'h0;
      wake_mode_out <= 1'b0;
      wake_irq_out <= 1'b0;
    end
    else
    begin
      wake_mode_out <= w_arm & sleep_s;
      wake_irq_out <= wake_ctl_reg[`SSP_WC_IE] &
                      (wake_ctl_reg[`SSP_WC_OVR] | wake_ctl_reg[`SSP_WC_DONE]);
      if (w_take)
      begin
        wake_shift_reg <= wake_ctl_reg[`SSP_WC_MSB] ? {wake_shift_reg[6:0], sdi_s} :
                          {sdi_s, wake_shift_reg[7:1]};
        wake_bits_reg <= wake_bits_reg + 3'h1;
      end
      else if (wr_wshift)
        wake_shift_reg <= wd_reg;
      if (!w_arm || w_acc)
        idle_bits_reg <= 4'h0;
      else if (ext_rise && idle_bits_reg != `SSP_WAKE_OVR_BITS)
        idle_bits_reg <= idle_bits_reg + 4'h1;
      if (wr_wctl)
        wake_ctl_reg <= wd_reg[5:0];
      if (w_done_set)
        wake_ctl_reg[`SSP_WC_DONE] <= 1'b1;
      if (w_ovr_set)
        wake_ctl_reg[`SSP_WC_OVR] <= 1'b1;
    end
  end
endmodule

// file: inc/ssp_consts.vh
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH
// ***************************************************************
// Register indexes (byte address is four times the index)
// ***************************************************************
`define SSP_IDX_SHIFT_DATA 16'hfe31
`define SSP_IDX_BIT_RATE 16'hfe32
`define SSP_IDX_CONT_LEN 16'hfe33
`define SSP_IDX_CONT_CTRL 16'hfe37
`define SSP_IDX_WAKE_SHIFT 16'hfedd
`define SSP_IDX_WAKE_CTRL 16'hfedf
`define SSP_IDX_PORT_CTRL 16'hfe40
// ***************************************************************
// Reset values
// ***************************************************************
`define SSP_RST_BYTE 8'h00
// ***************************************************************
// Continuous transfer control fields
// ***************************************************************
`define SSP_CC_PAUSE 7
`define SSP_CC_CODE_HI 6
`define SSP_CC_CODE_LO 5
// ***************************************************************
// Line code values
// ***************************************************************
`define SSP_CODE_NRZ 2'h0
`define SSP_CODE_MAN1 2'h1
`define SSP_CODE_BPS 2'h2
`define SSP_CODE_MAN2 2'h3
// ***************************************************************
// Wake control fields
// ***************************************************************
`define SSP_WC_ARM 5
`define SSP_WC_ACCEPT 4
`define SSP_WC_MSB 3
`define SSP_WC_OVR 2
`define SSP_WC_DONE 1
`define SSP_WC_IE 0
`define SSP_WAKE_OVR_BITS 4'ha
// ***************************************************************
// Port control fields
// ***************************************************************
`define SSP_PC_BANK 7
`define SSP_PC_SWAP 6
`define SSP_PC_RUN 5
`define SSP_PC_CONT 4
`define SSP_PC_MSB 3
`define SSP_PC_END 1
`define SSP_PC_EXT_CLK 0
// ***************************************************************
// RAM banks and timing
// ***************************************************************
`define SSP_RAM_BANK0 9'h1c0
`define SSP_RAM_BANK1 9'h1e0
`define SSP_TCYC_CLKS 3
`define SSP_RESP_OKAY 2'h0
`define SSP_RESP_SLVERR 2'h2
`endif

// file: verif/ssp_datapath_checker.sv
`timescale 1ns/1ps
module ssp_datapath_checker #(
  parameter TCYC_CLKS = 3
) (
  input wire clk_in,
  input wire reset_n_in,
  input wire s_axi_awready_out,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire sck_out,
  input wire [8:0] ram_addr_out,
  input wire ram_rd_out,
  input wire ram_wr_out
);
  // ****
  // Port relations
  // ****
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  a_bvalid_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read response changed early");
  a_write_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while response pending");
  a_read_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while response pending");
  a_rdata_upper: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_ram_window: assert property ((ram_rd_out || ram_wr_out) |-> ram_addr_out[8:6] == 3'h7)
    else $error("RAM access outside transfer area");
  a_rd_spacing: assert property (ram_rd_out |=> !ram_rd_out [*8])
    else $error("RAM reads too close");
  a_swap_after_rd: assert property (ram_wr_out |-> $past(ram_rd_out) || $past(ram_rd_out, 2))
    else $error("RAM write without preceding read");
  a_sck_half: assert property ($fell(sck_out) |=> !sck_out)
    else $error("transfer clock low phase too short");
endmodule

// file: verif/ssp_link_partner.sv
`timescale 1ns/1ps
module ssp_link_partner (
  input wire clk_in,
  input wire [8:0] ram_addr_in,
  input wire ram_rd_in,
  input wire ram_wr_in,
  input wire [7:0] ram_wdata_in,
  input wire sdo_in,
  output logic [7:0] ram_rdata_out,
  output logic sck_out,
  output wire sdi_out
);
  logic [7:0] mem [0:511];
  logic frame = 1'b0;
  logic bit_val = 1'b0;
  initial sck_out = 1'b1;
  // Loops transmit data back outside wake frames
  assign sdi_out = frame ? bit_val : sdo_in;
  // ****
  // RAM: data shown while the read strobe stands, scrambled otherwise
  // ****
  assign ram_rdata_out = ram_rd_in ? mem[ram_addr_in] : ~mem[ram_addr_in];
  always @(posedge clk_in)
  begin
    if (ram_wr_in)
      mem[ram_addr_in] <= ram_wdata_in;
  end
  // Wake frame: clock idles high, stands still between frames
  task send(input logic [7:0] b, input int n, input logic msb);
    int k;
    begin
      #3;
      frame = 1'b1;
      for (k = 0; k < n; k++)
      begin
        sck_out = 1'b0;
        bit_val = msb ? b[7 - k % 8] : b[k % 8];
        #80;
        sck_out = 1'b1;
        #80;
      end
      frame = 1'b0;
    end
  endtask
endmodule

// file: verif/tb_sync_serial_port_datapath.sv
`timescale 1ns/1ps
`include "ssp_consts.vh"
module tb_sync_serial_port_datapath;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] awaddr = 18'h0;
  logic [17:0] araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sleep = 1'b0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [1:0] resp;
  wire awready, wready, bvalid, arready, rvalid, sck_in, sck_out, sck_oe, sdi, sdo;
  wire wake_mode, irq, ram_rd, ram_wr;
  wire [8:0] ram_addr;
  wire [7:0] ram_wdata, ram_rdata;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int i;
  logic [15:0] regs [6] = '{`SSP_IDX_SHIFT_DATA, `SSP_IDX_BIT_RATE, `SSP_IDX_CONT_LEN,
    `SSP_IDX_CONT_CTRL, `SSP_IDX_WAKE_SHIFT, `SSP_IDX_WAKE_CTRL};
  always #5 clk = ~clk;
  ssp_datapath dut (.clk_in(clk), .reset_n_in(rst_n), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_out(sck_oe),
    .sdi_in(sdi), .sdo_out(sdo), .deep_sleep_in(sleep), .wake_mode_out(wake_mode),
    .wake_irq_out(irq), .ram_addr_out(ram_addr), .ram_rd_out(ram_rd), .ram_wr_out(ram_wr),
    .ram_wdata_out(ram_wdata), .ram_rdata_in(ram_rdata));
  ssp_link_partner peer (.clk_in(clk), .ram_addr_in(ram_addr), .ram_rd_in(ram_rd),
    .ram_wr_in(ram_wr), .ram_wdata_in(ram_wdata), .sdo_in(sdo), .ram_rdata_out(ram_rdata),
    .sck_out(sck_in), .sdi_out(sdi));
  // ****
  // Bus tasks and comparison
  // ****
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run++;
      if (got !== exp)
      begin
        bad_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input logic [15:0] idx, input logic [7:0] d);
    begin
      @(posedge clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
        @(posedge clk);
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
      end
      while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input logic [15:0] idx, output logic [31:0] d);
    begin
      @(posedge clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
        @(posedge clk);
        if (arready)
          arvalid <= 1'b0;
      end
      while (!rvalid);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
    end
  endtask
  task wait_run;
    do
      rd(`SSP_IDX_PORT_CTRL, v);
    while (v[`SSP_PC_RUN] !== 1'b0);
  endtask
  task test_done;
    begin
      if (bad_count == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      test_done;
    end
  end
  // ****
  // Test sequence
  // ****
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (i = 0; i < 6; i++)
    begin
      rd(regs[i], v);
      chk(v, 32'h0);
    end
    rd(16'hfe3f, v);
    chk({v[7:0], 22'h0, resp}, {30'h0, `SSP_RESP_SLVERR});
    wr(16'hfe3f, 8'h00);
    chk({30'h0, resp}, {30'h0, `SSP_RESP_SLVERR});
    wr(`SSP_IDX_CONT_CTRL, 8'hff);
    rd(`SSP_IDX_CONT_CTRL, v);
    chk(v, 32'he0);
    wr(`SSP_IDX_CONT_CTRL, 8'h00);
    wr(`SSP_IDX_BIT_RATE, 8'h03);
    // Sync 8-bit loopback, MSB first
    wr(`SSP_IDX_SHIFT_DATA, 8'h5a);
    wr(`SSP_IDX_PORT_CTRL, 8'h28);
    wait_run;
    chk(v & 32'h22, 32'h02);
    rd(`SSP_IDX_SHIFT_DATA, v);
    chk(v, 32'h5a);
    chk({31'h0, sck_oe}, 32'h1);
    // Line level after the last bit: Manchester one, bi-phase-space, Manchester two
    for (i = 1; i < 4; i++)
    begin
      wr(`SSP_IDX_CONT_CTRL, {1'b0, i[1:0], 5'h00});
      wr(`SSP_IDX_SHIFT_DATA, 8'h5b);
      wr(`SSP_IDX_PORT_CTRL, 8'h28);
      wait_run;
      chk({31'h0, sdo}, {31'h0, i != 1});
      rd(`SSP_IDX_SHIFT_DATA, v);
      if (i != 2)
        chk(v, 32'h5b);
    end
    wr(`SSP_IDX_PORT_CTRL, 8'h00);
    // Continuous 16 bits, bank 1, swap, paused after first byte
    peer.mem[9'h1e0] = 8'h3a;
    peer.mem[9'h1e1] = 8'h96;
    peer.mem[9'h1e2] = 8'h5c;
    wr(`SSP_IDX_SHIFT_DATA, 8'h33);
    wr(`SSP_IDX_CONT_LEN, 8'h0f);
    wr(`SSP_IDX_CONT_CTRL, 8'h80);
    wr(`SSP_IDX_PORT_CTRL, 8'hf8);
    do
      rd(`SSP_IDX_CONT_CTRL, v);
    while (v[4:0] !== 5'h01);
    repeat (100) @(posedge clk);
    rd(`SSP_IDX_PORT_CTRL, v);
    chk(v & 32'h20, 32'h20);
    wr(`SSP_IDX_CONT_CTRL, 8'h00);
    wait_run;
    rd(`SSP_IDX_CONT_CTRL, v);
    chk(v, 32'h02);
    rd(`SSP_IDX_SHIFT_DATA, v);
    chk(v, 32'h96);
    chk({24'h0, peer.mem[9'h1e0]}, 32'h33);
    chk({24'h0, peer.mem[9'h1e1]}, 32'h3a);
    chk({24'h0, peer.mem[9'h1e2]}, 32'h5c);
    // Continuous single bit, bank 0, copy only
    peer.mem[9'h1c0] = 8'ha5;
    wr(`SSP_IDX_PORT_CTRL, 8'h00);
    wr(`SSP_IDX_CONT_LEN, 8'h00);
    wr(`SSP_IDX_PORT_CTRL, 8'h38);
    wait_run;
    rd(`SSP_IDX_SHIFT_DATA, v);
    chk(v, 32'h4b);
    chk({24'h0, peer.mem[9'h1c0]}, 32'ha5);
    rd(`SSP_IDX_CONT_CTRL, v);
    chk(v, 32'h00);
    // Wake receive in both bit orders
    sleep <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      wr(`SSP_IDX_WAKE_CTRL, i == 0 ? 8'h38 : 8'h30);
      peer.send(8'hc1, 8, i == 0);
      rd(`SSP_IDX_WAKE_SHIFT, v);
      chk(v, 32'hc1);
      rd(`SSP_IDX_WAKE_CTRL, v);
      chk(v, i == 0 ? 32'h3a : 32'h32);
      chk({31'h0, wake_mode}, 32'h1);
    end
    wr(`SSP_IDX_WAKE_CTRL, 8'h33);
    rd(`SSP_IDX_WAKE_CTRL, v);
    chk({31'h0, irq}, 32'h1);
    wr(`SSP_IDX_WAKE_CTRL, 8'h32);
    rd(`SSP_IDX_WAKE_CTRL, v);
    chk({31'h0, irq}, 32'h0);
    // Overrun while armed but not accepting
    wr(`SSP_IDX_WAKE_CTRL, 8'h20);
    peer.send(8'h0f, 10, 1'b1);
    rd(`SSP_IDX_WAKE_CTRL, v);
    chk(v, 32'h24);
    rd(`SSP_IDX_WAKE_SHIFT, v);
    chk(v, 32'hc1);
    wr(`SSP_IDX_WAKE_CTRL, 8'h04);
    rd(`SSP_IDX_WAKE_CTRL, v);
    chk({31'h0, wake_mode}, 32'h0);
    wr(`SSP_IDX_WAKE_CTRL, 8'h00);
    // External clock, 8 bits MSB first from the partner
    wr(`SSP_IDX_PORT_CTRL, 8'h29);
    peer.send(8'h96, 8, 1'b1);
    wait_run;
    rd(`SSP_IDX_SHIFT_DATA, v);
    chk(v, 32'h96);
    chk({31'h0, sck_oe}, 32'h0);
    // Reset after the external-clock run returns registers to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`SSP_IDX_BIT_RATE, v);
    chk(v, 32'h0);
    test_done;
  end
endmodule
bind ssp_datapath ssp_datapath_checker #(.TCYC_CLKS(TCYC_CLKS)) u_chk (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .sck_out(sck_out), .ram_addr_out(ram_addr_out),
  .ram_rd_out(ram_rd_out), .ram_wr_out(ram_wr_out));
